// ---- verilog/gorc_top.sv ----
/*
 * gas reading output conditioner: warm-up hold, over-range clamp, fault
 * override, transient freeze, output polarity, serial reply and manual
 * calibration tie detection.
 * assumes reading, supply and checks come from core_clk logic;
 * rx and tx sense come from pins.
 */
`include "gorc_consts.svh"

module gorc_top #(
    parameter logic [31:0] WARMUP_CYCLES = 32'(`GORC_WARMUP_S * `GORC_CLK_HZ),
    parameter gorc_pkg::gorc_dac_t STARTUP_CODE = `GORC_ZERO_OUT,
    parameter gorc_pkg::gorc_dac_t ZERO_CODE = `GORC_ZERO_OUT,
    parameter gorc_pkg::gorc_dac_t FS_CODE = `GORC_FS_OUT,
    parameter logic [31:0] CAL_CYCLES = 32'(`GORC_CAL_MS * `GORC_CLK_HZ / 64'd1000),
    parameter logic [31:0] BAUD_DIV = 32'(`GORC_CLK_HZ / `GORC_BAUD)
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire gorc_pkg::gorc_reading_t meas_reading,
    input wire logic [12:0] supply_mv,
    input wire logic mem_check_ok,
    input wire logic analog_check_ok,
    input wire logic amb_temp_transient,
    input wire logic sample_temp_transient,
    input wire logic flow_transient,
    input wire logic out_falling,
    input wire logic cal_enable,
    input wire logic rx_pin,
    input wire logic tx_i,
    output logic tx_o,
    output logic tx_oe,
    output gorc_pkg::gorc_dac_t dac_code,
    output gorc_pkg::gorc_reading_t serial_reading,
    output logic warmup_active,
    output logic fault_active,
    output logic frozen,
    output logic zero_cmd,
    output logic span_cmd
);
    import gorc_pkg::*;

    gorc_uart_if uif();

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic txs_meta_reg;
    logic txs_sync_reg;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            txs_meta_reg <= 1'b1;
            txs_sync_reg <= 1'b1;
        end
        else
        begin
            rx_meta_reg <= rx_pin;
            rx_sync_reg <= rx_meta_reg;
            txs_meta_reg <= tx_i;
            txs_sync_reg <= txs_meta_reg;
        end
    end

    assign uif.rx_line = rx_sync_reg;

    // ------------------------------------------------------------------
    // warm-up timer
    // ------------------------------------------------------------------
    logic [31:0] warm_cnt_reg;
    logic warm_reg;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            warm_cnt_reg <= 32'h0;
            warm_reg <= 1'b1;
        end
        else if (warm_reg)
        begin
            warm_cnt_reg <= warm_cnt_reg + 32'd1;
            if (warm_cnt_reg >= WARMUP_CYCLES - 32'd1)
                warm_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // self-checks, clamp and freeze
    // ------------------------------------------------------------------
    // the limits are checked every cycle, so a fault shows within one clock
    wire supply_bad = (supply_mv < `GORC_SUPPLY_MIN_MV) || (supply_mv > `GORC_SUPPLY_MAX_MV);
    wire fault_now = supply_bad || !mem_check_ok || !analog_check_ok;
    wire transient = amb_temp_transient || sample_temp_transient || flow_transient;
    // values below -100% are also held at -100%, the lowest the output can show
    wire gorc_reading_t clamped = (meas_reading > `GORC_MAX_READING) ? `GORC_MAX_READING :
                                  (meas_reading < `GORC_FAULT_READING) ? `GORC_FAULT_READING : meas_reading;

    gorc_reading_t last_reg;
    wire gorc_reading_t live = transient ? last_reg : clamped;

    // ------------------------------------------------------------------
    // reading to output code, selectable slope
    // ------------------------------------------------------------------
    wire signed [15:0] span = $signed({4'h0, FS_CODE}) - $signed({4'h0, ZERO_CODE});
    wire signed [31:0] prod = live * span;
    wire signed [31:0] scaled = prod >>> `GORC_FS_SHIFT;
    wire signed [31:0] zero_w = $signed({20'h0, ZERO_CODE});
    wire signed [31:0] mapped = out_falling ? zero_w - scaled : zero_w + scaled;
    wire gorc_dac_t mapped_sat = (mapped < 32'sd0) ? 12'h000 :
                                 (mapped > $signed({20'h0, `GORC_DAC_MAX})) ? `GORC_DAC_MAX : mapped[11:0];

    // fault first, then warm-up, then the frozen or clamped value
    wire gorc_dac_t dac_next = fault_now ? `GORC_DAC_FAULT :
                               warm_reg ? STARTUP_CODE : mapped_sat;
    wire gorc_reading_t ser_next = fault_now ? `GORC_FAULT_READING :
                                   warm_reg ? `GORC_ZERO_READING : live;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            last_reg <= `GORC_ZERO_READING;
            dac_code <= `GORC_DAC_FAULT;
            serial_reading <= `GORC_ZERO_READING;
            fault_active <= 1'b0;
            frozen <= 1'b0;
        end
        else
        begin
            last_reg <= live;
            dac_code <= dac_next;
            serial_reading <= ser_next;
            fault_active <= fault_now;
            frozen <= transient && !fault_now;
        end
    end

    assign warmup_active = warm_reg;

    // ------------------------------------------------------------------
    // serial reply: a byte received while no reply is pending returns the reading, high byte first
    // ------------------------------------------------------------------
    gorc_reply_t reply_reg;
    gorc_reading_t snap_reg;

    assign uif.tx_valid = (reply_reg != GORC_REPLY_IDLE);
    assign uif.tx_data = (reply_reg == GORC_REPLY_HI) ? snap_reg[15:8] : snap_reg[7:0];

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            reply_reg <= GORC_REPLY_IDLE;
            snap_reg <= `GORC_ZERO_READING;
        end
        else
        begin
            unique case (reply_reg)
                GORC_REPLY_IDLE:
                    if (uif.rx_valid)
                    begin
                        snap_reg <= serial_reading;
                        reply_reg <= GORC_REPLY_HI;
                    end
                GORC_REPLY_HI:
                    if (uif.tx_ready)
                        reply_reg <= GORC_REPLY_LO;
                GORC_REPLY_LO:
                    if (uif.tx_ready)
                        reply_reg <= GORC_REPLY_IDLE;
            endcase
        end
    end

    gorc_uart #(
        .BAUD_DIV(BAUD_DIV)
    ) u_uart (
        .core_clk(core_clk),
        .reset(reset),
        .u(uif.port)
    );

    // in calibration mode the idle transmitter lets go so a tie to ground
    // neither fights the driver nor hides from the sense input
    assign tx_o = uif.tx_line;
    assign tx_oe = !cal_enable || uif.tx_busy;

    // ------------------------------------------------------------------
    // manual calibration: rx tied low alone gives zero, with tx gives span
    // ------------------------------------------------------------------
    logic [31:0] tie_cnt_reg;
    logic tie_both_reg;
    wire tie_long = (tie_cnt_reg >= CAL_CYCLES);
    wire tie_end = cal_enable && rx_sync_reg && tie_long;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            tie_cnt_reg <= 32'h0;
            tie_both_reg <= 1'b0;
            zero_cmd <= 1'b0;
            span_cmd <= 1'b0;
        end
        else
        begin
            zero_cmd <= tie_end && !tie_both_reg;
            span_cmd <= tie_end && tie_both_reg;
            if (!cal_enable || rx_sync_reg)
            begin
                tie_cnt_reg <= 32'h0;
                tie_both_reg <= 1'b0;
            end
            else
            begin
                if (!tie_long)
                    tie_cnt_reg <= tie_cnt_reg + 32'd1;
                if (!txs_sync_reg && !uif.tx_busy)
                    tie_both_reg <= 1'b1;
            end
        end
    end
endmodule

// ---- verilog/gorc_consts.svh ----
/*
 * constants of the conditioner: timing, scale, codes, limits.
 * assumes a 200 MHz core clock and a 12-bit output converter.
 */
// Notes on behaviour
// - output held at start-up level after power-up
// - hold lasts 15 s, then calculated value
// - serial reading is zero during warm-up
// - start-up level and warm-up time programmable
// - readings clamp at 200% of full scale
// - continuous memory, supply and analogue self-checks
// - fault forces output to -100% full scale
// - scaled voltage output goes to 0V code
// - serial reading is -100% during fault
// - transients freeze output until they settle
// - serial characters are 8N1 both directions
// - setting selects rising or falling output
// - pins tied low give zero/span command
`ifndef GORC_CONSTS_SVH
`define GORC_CONSTS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define GORC_CLK_HZ 64'd200000000
`define GORC_WARMUP_S 64'd15
`define GORC_CAL_MS 64'd100
`define GORC_BAUD 64'd9600

// ----------------------------------------------------------------------
// reading scale, full scale is 2^12
// ----------------------------------------------------------------------
`define GORC_FS_SHIFT 12
`define GORC_MAX_READING 16'sh2000
`define GORC_FAULT_READING 16'shF000
`define GORC_ZERO_READING 16'sh0000

// ----------------------------------------------------------------------
// output codes and self-check limits
// ----------------------------------------------------------------------
`define GORC_ZERO_OUT 12'h249
`define GORC_FS_OUT 12'hB6D
`define GORC_DAC_MAX 12'hFFF
`define GORC_DAC_FAULT 12'h000
`define GORC_SUPPLY_MIN_MV 13'h0BB8
`define GORC_SUPPLY_MAX_MV 13'h1388

`endif

// ---- verilog/gorc_pkg.sv ----
/*
 * types shared by the conditioner and its serial port.
 * assumes nothing beyond the constants header.
 */
package gorc_pkg;
    typedef logic signed [15:0] gorc_reading_t;
    typedef logic [11:0] gorc_dac_t;
    typedef logic [7:0] gorc_byte_t;
    typedef enum logic [1:0] {GORC_REPLY_IDLE, GORC_REPLY_HI, GORC_REPLY_LO} gorc_reply_t;
    typedef enum logic [1:0] {GORC_UART_IDLE, GORC_UART_START, GORC_UART_DATA, GORC_UART_STOP} gorc_uart_st_t;
endpackage

// ---- verilog/gorc_uart_if.sv ----
/*
 * byte channel to the serial port.
 * assumes both ends run on core_clk; rx_line is already synchronised.
 */
interface gorc_uart_if;
    gorc_pkg::gorc_byte_t tx_data;
    logic tx_valid;
    logic tx_ready;
    logic tx_line;
    logic tx_busy;
    gorc_pkg::gorc_byte_t rx_data;
    logic rx_valid;
    logic rx_line;
    modport core (output tx_data, output tx_valid, input tx_ready, input tx_line, input tx_busy,
                  input rx_data, input rx_valid, output rx_line);
    modport port (input tx_data, input tx_valid, output tx_ready, output tx_line, output tx_busy,
                  output rx_data, output rx_valid, input rx_line);
endinterface

// ---- verilog/gorc_uart.sv ----
/*
 * 8N1 transmitter and receiver, data lsb first.
 * assumes rx_line is synchronised; a byte whose stop bit is low is dropped.
 */
module gorc_uart #(
    parameter logic [31:0] BAUD_DIV = 32'd20833
) (
    input wire logic core_clk,
    input wire logic reset,
    gorc_uart_if.port u
);
    import gorc_pkg::*;

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    gorc_uart_st_t tx_st_reg;
    logic [31:0] tx_cnt_reg;
    logic [2:0] tx_bit_reg;
    gorc_byte_t tx_sh_reg;
    logic tx_line_reg;
    wire tx_tick = (tx_cnt_reg == BAUD_DIV - 32'd1);

    assign u.tx_ready = (tx_st_reg == GORC_UART_IDLE);
    assign u.tx_busy = (tx_st_reg != GORC_UART_IDLE);
    assign u.tx_line = tx_line_reg;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_st_reg <= GORC_UART_IDLE;
            tx_cnt_reg <= 32'h0;
            tx_bit_reg <= 3'h0;
            tx_sh_reg <= 8'h00;
            tx_line_reg <= 1'b1;
        end
        else
        begin
            tx_cnt_reg <= (tx_st_reg == GORC_UART_IDLE || tx_tick) ? 32'h0 : tx_cnt_reg + 32'd1;
            unique case (tx_st_reg)
                GORC_UART_IDLE:
                    if (u.tx_valid)
                    begin
                        tx_sh_reg <= u.tx_data;
                        tx_line_reg <= 1'b0;
                        tx_st_reg <= GORC_UART_START;
                    end
                GORC_UART_START:
                    if (tx_tick)
                    begin
                        tx_line_reg <= tx_sh_reg[0];
                        tx_bit_reg <= 3'h0;
                        tx_st_reg <= GORC_UART_DATA;
                    end
                GORC_UART_DATA:
                    if (tx_tick)
                    begin
                        if (tx_bit_reg == 3'h7)
                        begin
                            tx_line_reg <= 1'b1;
                            tx_st_reg <= GORC_UART_STOP;
                        end
                        else
                        begin
                            tx_line_reg <= tx_sh_reg[tx_bit_reg + 3'h1];
                            tx_bit_reg <= tx_bit_reg + 3'h1;
                        end
                    end
                GORC_UART_STOP:
                    if (tx_tick)
                        tx_st_reg <= GORC_UART_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // receiver, sampled at mid-bit
    // ------------------------------------------------------------------
    gorc_uart_st_t rx_st_reg;
    logic [31:0] rx_cnt_reg;
    logic [2:0] rx_bit_reg;
    gorc_byte_t rx_sh_reg;
    gorc_byte_t rx_data_reg;
    logic rx_valid_reg;
    wire [31:0] rx_limit = (rx_st_reg == GORC_UART_START) ? (BAUD_DIV >> 1) : BAUD_DIV - 32'd1;
    wire rx_tick = (rx_cnt_reg == rx_limit);

    assign u.rx_data = rx_data_reg;
    assign u.rx_valid = rx_valid_reg;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_st_reg <= GORC_UART_IDLE;
            rx_cnt_reg <= 32'h0;
            rx_bit_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
            rx_data_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
        end
        else
        begin
            rx_valid_reg <= 1'b0;
            rx_cnt_reg <= (rx_st_reg == GORC_UART_IDLE || rx_tick) ? 32'h0 : rx_cnt_reg + 32'd1;
            unique case (rx_st_reg)
                GORC_UART_IDLE:
                    if (!u.rx_line)
                        rx_st_reg <= GORC_UART_START;
                GORC_UART_START:
                    if (rx_tick)
                    begin
                        rx_bit_reg <= 3'h0;
                        rx_st_reg <= u.rx_line ? GORC_UART_IDLE : GORC_UART_DATA;
                    end
                GORC_UART_DATA:
                    if (rx_tick)
                    begin
                        rx_sh_reg <= {u.rx_line, rx_sh_reg[7:1]};
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == 3'h7)
                            rx_st_reg <= GORC_UART_STOP;
                    end
                GORC_UART_STOP:
                    if (rx_tick)
                    begin
                        // a low stop bit is a framing error or a calibration tie
                        rx_valid_reg <= u.rx_line;
                        rx_data_reg <= rx_sh_reg;
                        rx_st_reg <= GORC_UART_IDLE;
                    end
            endcase
        end
    end
endmodule

// ---- dv/gorc_top_asserts.sv ----
/*
 * port checks of the conditioner.
 * assumes one clock; bound below.
 */
`include "gorc_consts.svh"

module gorc_top_asserts #(
    parameter logic [31:0] WARMUP_CYCLES = 32'd100,
    parameter gorc_pkg::gorc_dac_t STARTUP_CODE = `GORC_ZERO_OUT,
    parameter logic [31:0] CAL_CYCLES = 32'd20
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire gorc_pkg::gorc_reading_t meas_reading,
    input wire logic [12:0] supply_mv,
    input wire logic mem_check_ok,
    input wire logic analog_check_ok,
    input wire logic amb_temp_transient,
    input wire logic sample_temp_transient,
    input wire logic flow_transient,
    input wire logic cal_enable,
    input wire logic rx_pin,
    input wire gorc_pkg::gorc_dac_t dac_code,
    input wire gorc_pkg::gorc_reading_t serial_reading,
    input wire logic warmup_active,
    input wire logic fault_active,
    input wire logic frozen,
    input wire logic zero_cmd,
    input wire logic span_cmd
);
    import gorc_pkg::*;
    logic [31:0] up_cnt, low_cnt, last_low;
    wire ok_in = mem_check_ok && analog_check_ok && supply_mv >= `GORC_SUPPLY_MIN_MV
                 && supply_mv <= `GORC_SUPPLY_MAX_MV;
    wire trans_in = amb_temp_transient || sample_temp_transient || flow_transient;

    // saturating, so a long run never re-enters warm-up
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            up_cnt <= 32'h0;
            low_cnt <= 32'h0;
            last_low <= 32'h0;
        end
        else
        begin
            up_cnt <= (up_cnt < WARMUP_CYCLES) ? up_cnt + 32'h1 : up_cnt;
            low_cnt <= rx_pin ? 32'h0 : low_cnt + 32'h1;
            last_low <= (rx_pin && low_cnt != 32'h0) ? low_cnt : last_low;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_fault_memory: assert property (!mem_check_ok |=> fault_active && dac_code == `GORC_DAC_FAULT
        && serial_reading == `GORC_FAULT_READING) else $error("mem fault missed");
    chk_fault_supply: assert property ((supply_mv < `GORC_SUPPLY_MIN_MV || supply_mv > `GORC_SUPPLY_MAX_MV)
        |=> fault_active && dac_code == `GORC_DAC_FAULT) else $error("supply fault missed");
    chk_fault_outranks: assert property (!analog_check_ok && (trans_in || warmup_active || meas_reading > 16'sh2000)
        |=> serial_reading == `GORC_FAULT_READING && !frozen) else $error("fault lost priority");
    chk_warm_serial_zero: assert property (warmup_active && !fault_active |-> serial_reading == 16'sh0000)
        else $error("warm-up serial nonzero");
    chk_warm_start_level: assert property (warmup_active && !fault_active && !$past(reset)
        |-> dac_code == STARTUP_CODE) else $error("start-up level wrong");
    chk_warm_length: assert property (warmup_active == (up_cnt < WARMUP_CYCLES))
        else $error("warm-up length wrong");
    chk_clamp_top: assert property (ok_in && !trans_in && !warmup_active && meas_reading > `GORC_MAX_READING
        |=> serial_reading == `GORC_MAX_READING) else $error("over-range not clamped");
    chk_freeze_holds: assert property (frozen && !warmup_active && ok_in && trans_in |=> $stable(serial_reading))
        else $error("frozen reading moved");
    chk_freeze_flag: assert property (ok_in && trans_in |=> frozen)
        else $error("no freeze");
    chk_cal_cause: assert property (zero_cmd || span_cmd |-> cal_enable && last_low >= CAL_CYCLES
        && !(zero_cmd && span_cmd)) else $error("cal command without tie");
    chk_cal_answer: assert property (cal_enable && rx_pin && low_cnt >= CAL_CYCLES + 32'd2
        |-> ##[1:6] (zero_cmd || span_cmd)) else $error("cal tie ignored");
endmodule

bind gorc_top gorc_top_asserts #(.WARMUP_CYCLES(WARMUP_CYCLES), .STARTUP_CODE(STARTUP_CODE), .CAL_CYCLES(CAL_CYCLES))
    i_chk (.core_clk(core_clk), .reset(reset), .meas_reading(meas_reading), .supply_mv(supply_mv),
    .mem_check_ok(mem_check_ok), .analog_check_ok(analog_check_ok), .amb_temp_transient(amb_temp_transient),
    .sample_temp_transient(sample_temp_transient), .flow_transient(flow_transient), .cal_enable(cal_enable),
    .rx_pin(rx_pin), .dac_code(dac_code), .serial_reading(serial_reading), .warmup_active(warmup_active),
    .fault_active(fault_active), .frozen(frozen), .zero_cmd(zero_cmd), .span_cmd(span_cmd));

// ---- dv/gorc_host_model.sv ----
/*
 * host on the serial pins: requests, replies, pin ties.
 * assumes a pull-up on tx while undriven.
 */
module gorc_host_model #(
    parameter int BAUD_DIV = 16
) (
    input wire logic core_clk,
    input wire logic tx_o,
    input wire logic tx_oe,
    output logic rx_pin,
    output logic tx_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tie_tx = 1'b0;
    initial
        rx_pin = 1'b1;
    assign tx_i = tx_oe ? tx_o : !tie_tx;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            rx_pin <= frame[i];
            repeat (BAUD_DIV - 1) @(posedge core_clk);
        end
    endtask

    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        ok = 1'b0;
        b = 8'h00;
        for (n = 0; tx_i !== 1'b0 && n < 64 * BAUD_DIV; n++)
            @(posedge core_clk);
        if (n < 64 * BAUD_DIV)
        begin
            repeat (BAUD_DIV / 2) @(posedge core_clk);
            ok = (tx_i === 1'b0);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BAUD_DIV) @(posedge core_clk);
                b[i] = tx_i;
            end
            repeat (BAUD_DIV) @(posedge core_clk);
            ok = ok && (tx_i === 1'b1);
        end
    endtask

    task automatic recv_word(output logic [15:0] w, output logic ok, output logic ovr);
        logic ok_lo;
        recv_byte(w[15:8], ok);
        recv_byte(w[7:0], ok_lo);
        ok = ok && ok_lo;
        // full scale is linear, so over-range is the host's call
        ovr = $signed(w) > 16'sh1000;
    endtask

    task automatic tie(input int n, input logic with_tx);
        @(posedge core_clk);
        rx_pin <= 1'b0;
        tie_tx <= with_tx;
        repeat (n) @(posedge core_clk);
        rx_pin <= 1'b1;
        tie_tx <= 1'b0;
    endtask
endmodule

// ---- dv/gorc_top_tb.sv ----
/*
 * bench of the conditioner.
 * assumes the host model and the bound checker.
 */
module gorc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gorc_pkg::*;
    localparam int WARM = 400;
    localparam int BAUD = 16;
    localparam int CAL = 20;
    localparam gorc_dac_t START = 12'h3C0;
    logic core_clk, reset, mem_ok, an_ok, out_falling, cal_enable, rx_pin, tx_i, tx_o, tx_oe;
    logic warmup_active, fault_active, frozen, zero_cmd, span_cmd;
    logic [2:0] trans;
    logic [12:0] supply_mv;
    gorc_reading_t meas_reading, serial_reading;
    gorc_dac_t dac_code;
    int errors, n_compared;

    gorc_top #(.WARMUP_CYCLES(WARM), .STARTUP_CODE(START), .CAL_CYCLES(CAL), .BAUD_DIV(BAUD)) i_dut (
        .core_clk(core_clk), .reset(reset), .meas_reading(meas_reading), .supply_mv(supply_mv),
        .mem_check_ok(mem_ok), .analog_check_ok(an_ok), .amb_temp_transient(trans[0]),
        .sample_temp_transient(trans[1]), .flow_transient(trans[2]), .out_falling(out_falling),
        .cal_enable(cal_enable), .rx_pin(rx_pin), .tx_i(tx_i), .tx_o(tx_o), .tx_oe(tx_oe), .dac_code(dac_code),
        .serial_reading(serial_reading), .warmup_active(warmup_active), .fault_active(fault_active),
        .frozen(frozen), .zero_cmd(zero_cmd), .span_cmd(span_cmd));
    gorc_host_model #(.BAUD_DIV(BAUD)) i_host (.core_clk(core_clk), .tx_o(tx_o), .tx_oe(tx_oe), .rx_pin(rx_pin),
        .tx_i(tx_i));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic drive(input gorc_reading_t m, input logic [12:0] s, input logic mo, input logic ao,
                         input logic [2:0] tr);
        @(posedge core_clk);
        meas_reading <= m;
        supply_mv <= s;
        mem_ok <= mo;
        an_ok <= ao;
        trans <= tr;
        step(2);
    endtask

    task automatic ask(input logic [15:0] exp);
        logic [15:0] w;
        logic ok, ovr;
        fork
            i_host.send_byte(8'h5A);
            i_host.recv_word(w, ok, ovr);
        join
        chk("framing", 16'h0001, {15'h0, ok});
        chk("reply", exp, w);
        chk("over_range", {15'h0, $signed(exp) > 16'sh1000}, {15'h0, ovr});
        if (ok !== 1'b1)
            tally_and_finish();
    endtask

    task automatic t_warmup;
        int n;
        drive(16'sh0800, 13'h1388, 1'b1, 1'b1, 3'b000);
        chk("warm_dac", 16'(START), 16'(dac_code));
        chk("warm_serial", 16'h0000, serial_reading);
        ask(16'h0000);
        for (n = 0; warmup_active === 1'b1 && n < 2 * WARM; n++)
            step(1);
        step(2);
        chk("warm_flag", 16'h0000, {15'h0, warmup_active});
        chk("live_dac", 16'h06DB, 16'(dac_code));
        chk("live_serial", 16'h0800, serial_reading);
    endtask

    task automatic t_polarity;
        drive(16'sh0200, 13'h0BB8, 1'b1, 1'b1, 3'b000);
        chk("rising_dac", 16'h036D, 16'(dac_code));
        @(posedge core_clk);
        out_falling <= 1'b1;
        step(2);
        chk("falling_dac", 16'h0125, 16'(dac_code));
        @(posedge core_clk);
        out_falling <= 1'b0;
    endtask

    task automatic t_clamp;
        gorc_reading_t m[4] = '{16'sh3000, 16'sh2000, 16'sh1FFF, 16'sh7FFF};
        gorc_reading_t e[4] = '{16'sh2000, 16'sh2000, 16'sh1FFF, 16'sh2000};
        for (int i = 0; i < 4; i++)
        begin
            drive(m[i], 13'h1000, 1'b1, 1'b1, 3'b000);
            chk("clamped", e[i], serial_reading);
        end
        ask(16'h2000);
    endtask

    task automatic t_fault;
        for (int i = 0; i < 4; i++)
        begin
            drive(16'sh3000, i == 2 ? 13'h0BB7 : (i == 3 ? 13'h1389 : 13'h1000), i != 0, i != 1,
                  i == 1 ? 3'b111 : 3'b000);
            chk("fault_flag", 16'h0001, {15'h0, fault_active});
            chk("fault_dac", 16'h0000, 16'(dac_code));
            chk("fault_serial", 16'hF000, serial_reading);
        end
        ask(16'hF000);
        drive(16'sh0100, 13'h1000, 1'b1, 1'b1, 3'b000);
        chk("fault_gone", 16'h0000, {15'h0, fault_active});
    endtask

    task automatic t_freeze;
        for (int k = 0; k < 3; k++)
        begin
            drive(16'sh0100, 13'h1000, 1'b1, 1'b1, 3'b000);
            drive(16'sh0500, 13'h1000, 1'b1, 1'b1, 3'(3'b001 << k));
            chk("frozen_flag", 16'h0001, {15'h0, frozen});
            chk("frozen_value", 16'h0100, serial_reading);
            drive(16'sh0500, 13'h1000, 1'b1, 1'b1, 3'b000);
            chk("thawed", 16'h0500, serial_reading);
        end
    endtask

    task automatic t_cal;
        int z, s;
        @(posedge core_clk);
        cal_enable <= 1'b1;
        step(2);
        chk("tx_oe", 16'h0000, {15'h0, tx_oe});
        for (int k = 0; k < 3; k++)
        begin
            z = 0;
            s = 0;
            i_host.tie(k == 2 ? CAL / 2 : CAL + 10, k == 1);
            for (int c = 0; c < 12; c++)
            begin
                step(1);
                z += int'(zero_cmd === 1'b1);
                s += int'(span_cmd === 1'b1);
            end
            chk("zero_cmd", 16'(k == 0), 16'(z));
            chk("span_cmd", 16'(k == 1), 16'(s));
        end
    endtask

    initial
    begin
        repeat (100000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end

    initial
    begin
        errors = 0;
        n_compared = 0;
        reset = 1'b1;
        meas_reading = 16'sh0000;
        supply_mv = 13'h1000;
        mem_ok = 1'b1;
        an_ok = 1'b1;
        trans = 3'b000;
        out_falling = 1'b0;
        cal_enable = 1'b0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        t_warmup();
        t_polarity();
        t_clamp();
        t_fault();
        t_freeze();
        t_cal();
        tally_and_finish();
    end
endmodule
